// file: prox_threshold_pkg.sv
// shared offsets, widths and reset values of the proximity threshold bank
`default_nettype none
package prox_threshold_pkg;
    localparam int          DATA_W        = 8;
    localparam int          ADDR_W        = 8;
    localparam int          THRESH_W      = 16;
    localparam logic [7:0]  PROX1_LOW_OFF = 8'h11;
    localparam logic [7:0]  PROX1_HIGH_OFF = 8'h12;
    localparam logic [7:0]  PROX2_LOW_OFF = 8'h13;
    localparam logic [7:0]  PROX2_HIGH_OFF = 8'h14;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ = 8'h00;
endpackage
`default_nettype wire

// file: prox_threshold_cmp.sv
// one channel's measurement against threshold comparison, registered event
`default_nettype none
module prox_threshold_cmp
#(
    parameter int W = 16
)
(
    input  wire logic         ref_clk,
    input  wire logic         reset_n,
    input  wire logic         meas_valid,
    input  wire logic [W-1:0] meas_value,
    input  wire logic [W-1:0] threshold,
    input  wire logic         above_sel,
    output var  logic         hit_r
);
    typedef struct packed {
        logic hit;
    } cmp_state_t;

    cmp_state_t st_r;
    cmp_state_t st_nxt;

    always_comb
    begin
        st_nxt = st_r;
        // full-width compare; direction comes from outside config
        st_nxt.hit = meas_valid &&
                     (above_sel ? (meas_value > threshold)
                                : (meas_value < threshold));
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign hit_r = st_r.hit;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    chk_event_above: assert property (
        meas_valid && above_sel && (meas_value > threshold) |=> hit_r)
        else $error("missed above-threshold event");
    chk_event_below: assert property (
        meas_valid && !above_sel && (meas_value >= threshold) |=> !hit_r)
        else $error("spurious below-threshold event");
    chk_event_cause: assert property (
        hit_r |-> $past(meas_valid))
        else $error("event without a measurement");
    cov_event_hit: cover property (meas_valid ##1 hit_r);
endmodule
`default_nettype wire

// file: proximity_threshold_regs.sv
// proximity threshold register bank with per-channel event comparison
// Summary of operation
// - first channel threshold is 16 bits, low byte 0x11, high 0x12.
// - first channel measurements are compared with its threshold for events.
// - second channel threshold is 16 bits, low byte at 0x13.
// - second channel measurements are compared with its threshold for events.
// - second channel threshold high byte sits at 0x14.
// - each byte takes effect at once; mixed thresholds are possible.
// - all threshold bytes reset to zero; all are read/write except the high bytes, which are unmapped in legacy mode.
// - legacy revisions use one 8-bit threshold at 0x11 and 0x13.
`default_nettype none
module proximity_threshold_regs
(
    input  wire logic                                   ref_clk,
    input  wire logic                                   reset_n,
    input  wire logic [prox_threshold_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic                                   reg_wr,
    input  wire logic                                   reg_rd,
    input  wire logic [prox_threshold_pkg::DATA_W-1:0]  reg_wdata,
    output var  logic [prox_threshold_pkg::DATA_W-1:0]  reg_rdata_r,
    input  wire logic                                   legacy_mode,
    input  wire logic                                   above_sel,
    input  wire logic                                   meas1_valid,
    input  wire logic [prox_threshold_pkg::THRESH_W-1:0] meas1_value,
    input  wire logic                                   meas2_valid,
    input  wire logic [prox_threshold_pkg::THRESH_W-1:0] meas2_value,
    output var  logic [prox_threshold_pkg::THRESH_W-1:0] prox1_threshold,
    output var  logic [prox_threshold_pkg::THRESH_W-1:0] prox2_threshold,
    output var  logic                                   prox1_event,
    output var  logic                                   prox2_event
);
    typedef struct packed {
        logic [7:0] th1_lo;
        logic [7:0] th1_hi;
        logic [7:0] th2_lo;
        logic [7:0] th2_hi;
        logic [7:0] rdata;
    } regs_state_t;

    regs_state_t st_r;
    regs_state_t st_nxt;

    logic [15:0] eff_th   [2];
    logic [15:0] meas_val [2];
    logic        meas_vld [2];
    logic        hit      [2];

    // high bytes vanish from the map in legacy mode
    function automatic logic addr_hit(input logic [7:0] a,
                                      input logic [7:0] off,
                                      input logic       high,
                                      input logic       legacy);
        addr_hit = (a == off) && !(high && legacy);
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        // bytes land immediately; no shadowing of the pair
        if (reg_wr)
        begin
            if (addr_hit(reg_addr, prox_threshold_pkg::PROX1_LOW_OFF,
                         1'b0, legacy_mode))
                st_nxt.th1_lo = reg_wdata;
            else if (addr_hit(reg_addr, prox_threshold_pkg::PROX1_HIGH_OFF,
                              1'b1, legacy_mode))
                st_nxt.th1_hi = reg_wdata;
            else if (addr_hit(reg_addr, prox_threshold_pkg::PROX2_LOW_OFF,
                              1'b0, legacy_mode))
                st_nxt.th2_lo = reg_wdata;
            else if (addr_hit(reg_addr, prox_threshold_pkg::PROX2_HIGH_OFF,
                              1'b1, legacy_mode))
                st_nxt.th2_hi = reg_wdata;
        end
        if (reg_rd)
        begin
            if (addr_hit(reg_addr, prox_threshold_pkg::PROX1_LOW_OFF,
                         1'b0, legacy_mode))
                st_nxt.rdata = st_r.th1_lo;
            else if (addr_hit(reg_addr, prox_threshold_pkg::PROX1_HIGH_OFF,
                              1'b1, legacy_mode))
                st_nxt.rdata = st_r.th1_hi;
            else if (addr_hit(reg_addr, prox_threshold_pkg::PROX2_LOW_OFF,
                              1'b0, legacy_mode))
                st_nxt.rdata = st_r.th2_lo;
            else if (addr_hit(reg_addr, prox_threshold_pkg::PROX2_HIGH_OFF,
                              1'b1, legacy_mode))
                st_nxt.rdata = st_r.th2_hi;
            else
                st_nxt.rdata = prox_threshold_pkg::UNMAPPED_READ;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            st_r.th1_lo <= prox_threshold_pkg::BYTE_RESET;
            st_r.th1_hi <= prox_threshold_pkg::BYTE_RESET;
            st_r.th2_lo <= prox_threshold_pkg::BYTE_RESET;
            st_r.th2_hi <= prox_threshold_pkg::BYTE_RESET;
            st_r.rdata  <= prox_threshold_pkg::UNMAPPED_READ;
        end
        else
            st_r <= st_nxt;
    end

    assign reg_rdata_r     = st_r.rdata;
    assign prox1_threshold = {st_r.th1_hi, st_r.th1_lo};
    assign prox2_threshold = {st_r.th2_hi, st_r.th2_lo};

    // legacy byte is passed zero-extended; its expansion lives upstream
    always_comb
    begin
        eff_th[0] = legacy_mode ? {8'h00, st_r.th1_lo}
                                : {st_r.th1_hi, st_r.th1_lo};
        eff_th[1] = legacy_mode ? {8'h00, st_r.th2_lo}
                                : {st_r.th2_hi, st_r.th2_lo};
        meas_val[0] = meas1_value;
        meas_val[1] = meas2_value;
        meas_vld[0] = meas1_valid;
        meas_vld[1] = meas2_valid;
    end

    // a compare mid-update sees whatever bytes are stored right now
    for (genvar ch = 0; ch < 2; ch++)
    begin : g_cmp
        prox_threshold_cmp #(
            .W          (prox_threshold_pkg::THRESH_W)
        ) u_cmp (
            .ref_clk    (ref_clk),
            .reset_n    (reset_n),
            .meas_valid (meas_vld[ch]),
            .meas_value (meas_val[ch]),
            .threshold  (eff_th[ch]),
            .above_sel  (above_sel),
            .hit_r      (hit[ch])
        );
    end

    assign prox1_event = hit[0];
    assign prox2_event = hit[1];

    default clocking cb @(posedge ref_clk); endclocking

    // each byte lands alone on the edge after its strobe
    chk_write_low1: assert property (disable iff (!reset_n)
        reg_wr && reg_addr == prox_threshold_pkg::PROX1_LOW_OFF
        |=> prox1_threshold[7:0] == $past(reg_wdata))
        else $error("first low byte write lost");
    chk_write_high1: assert property (disable iff (!reset_n)
        reg_wr && !legacy_mode
        && reg_addr == prox_threshold_pkg::PROX1_HIGH_OFF
        |=> prox1_threshold[15:8] == $past(reg_wdata))
        else $error("first high byte write lost");
    chk_write_low2: assert property (disable iff (!reset_n)
        reg_wr && reg_addr == prox_threshold_pkg::PROX2_LOW_OFF
        |=> prox2_threshold[7:0] == $past(reg_wdata))
        else $error("second low byte write lost");
    chk_write_high2: assert property (disable iff (!reset_n)
        reg_wr && !legacy_mode
        && reg_addr == prox_threshold_pkg::PROX2_HIGH_OFF
        |=> prox2_threshold[15:8] == $past(reg_wdata))
        else $error("second high byte write lost");
    // the partner byte never moves, so a half update stays visible
    chk_mixed_bytes: assert property (disable iff (!reset_n)
        reg_wr && reg_addr == prox_threshold_pkg::PROX1_LOW_OFF
        |=> $stable(prox1_threshold[15:8]))
        else $error("low write disturbed high byte");
    chk_mixed_bytes2: assert property (disable iff (!reset_n)
        reg_wr && reg_addr == prox_threshold_pkg::PROX2_HIGH_OFF
        |=> $stable(prox2_threshold[7:0]))
        else $error("high write disturbed low byte");
    chk_reset_zero: assert property (
        !reset_n
        |=> prox1_threshold == {2{prox_threshold_pkg::BYTE_RESET}}
            && prox2_threshold == {2{prox_threshold_pkg::BYTE_RESET}}
            && reg_rdata_r == prox_threshold_pkg::UNMAPPED_READ
            && !prox1_event && !prox2_event)
        else $error("thresholds not cleared by reset");
    chk_read_low1: assert property (disable iff (!reset_n)
        reg_rd && reg_addr == prox_threshold_pkg::PROX1_LOW_OFF
        |=> reg_rdata_r == $past(prox1_threshold[7:0]))
        else $error("low byte read mismatch");
    chk_read_back: assert property (disable iff (!reset_n)
        reg_rd && !legacy_mode
        && reg_addr == prox_threshold_pkg::PROX2_HIGH_OFF
        |=> reg_rdata_r == $past(prox2_threshold[15:8]))
        else $error("high byte read mismatch");
    chk_unmapped_read: assert property (disable iff (!reset_n)
        reg_rd && (reg_addr < prox_threshold_pkg::PROX1_LOW_OFF
                   || reg_addr > prox_threshold_pkg::PROX2_HIGH_OFF)
        |=> reg_rdata_r == prox_threshold_pkg::UNMAPPED_READ)
        else $error("unmapped read not zero");
    // host may sample read data late, so it must hold between strobes
    chk_rd_stands: assert property (disable iff (!reset_n)
        !reg_rd |=> $stable(reg_rdata_r))
        else $error("read data moved without a read");
    chk_legacy_high: assert property (disable iff (!reset_n)
        reg_rd && legacy_mode
        && reg_addr == prox_threshold_pkg::PROX1_HIGH_OFF
        |=> reg_rdata_r == prox_threshold_pkg::UNMAPPED_READ)
        else $error("legacy high byte visible");
    chk_legacy_keep: assert property (disable iff (!reset_n)
        reg_wr && legacy_mode
        && reg_addr == prox_threshold_pkg::PROX2_HIGH_OFF
        |=> $stable(prox2_threshold[15:8]))
        else $error("legacy write reached a high byte");
    chk_event_path: assert property (disable iff (!reset_n)
        meas1_valid && above_sel && !legacy_mode
        && meas1_value > prox1_threshold |=> prox1_event)
        else $error("first channel event missing");
    chk_event_path2: assert property (disable iff (!reset_n)
        meas2_valid && !above_sel && !legacy_mode
        && meas2_value < prox2_threshold |=> prox2_event)
        else $error("second channel event missing");
    // legacy compare must ignore whatever the high byte still holds
    chk_legacy_cmp: assert property (disable iff (!reset_n)
        meas1_valid && above_sel && legacy_mode
        && meas1_value > {8'h00, prox1_threshold[7:0]} |=> prox1_event)
        else $error("legacy compare used the high byte");

    cov_write_pair: cover property (disable iff (!reset_n)
        reg_wr && reg_addr == 8'h11 ##1 reg_wr && reg_addr == 8'h12);
    cov_legacy_cmp: cover property (disable iff (!reset_n)
        legacy_mode && meas2_valid ##1 prox2_event);
    cov_read_back: cover property (disable iff (!reset_n)
        reg_rd && reg_addr == 8'h13);
    cov_update_cmp: cover property (disable iff (!reset_n)
        reg_wr ##[1:8] meas1_valid);
endmodule
`default_nettype wire

// file: host_model.sv
// host model driving the byte register bus of the threshold bank
`default_nettype none
module host_model
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] reg_rdata_r,
    output var  logic [7:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
    end
    // callers run no measurement while a byte is in flight
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        // released bus is scrambled so a stale value cannot pass
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        @(negedge ref_clk);
        d = reg_rdata_r;
    endtask
endmodule
`default_nettype wire

// file: proximity_threshold_regs_tb_top.sv
// self-checking bench for the proximity threshold register bank
`default_nettype none
module proximity_threshold_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        ref_clk;
    logic        reset_n;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata_r;
    logic        reg_wr;
    logic        reg_rd;
    logic        legacy_mode;
    logic        above_sel;
    logic        m1_v;
    logic        m2_v;
    logic [15:0] m1;
    logic [15:0] m2;
    logic [15:0] th1;
    logic [15:0] th2;
    logic        ev1;
    logic        ev2;
    logic [7:0]  mem [4];
    logic [31:0] seed = 32'h0000000b;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;
    proximity_threshold_regs u_dut
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata_r(reg_rdata_r), .legacy_mode(legacy_mode),
        .above_sel(above_sel), .meas1_valid(m1_v), .meas1_value(m1),
        .meas2_valid(m2_v), .meas2_value(m2), .prox1_threshold(th1),
        .prox2_threshold(th2), .prox1_event(ev1), .prox2_event(ev2)
    );
    host_model u_host
    (
        .ref_clk(ref_clk), .reg_rdata_r(reg_rdata_r), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata)
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            failures = failures + 1;
            test_done();
        end
    end
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic hit(logic [15:0] m, logic [15:0] t);
        return above_sel ? (m > t) : (m < t);
    endfunction
    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        total_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic meas(logic [15:0] a, logic [15:0] b);
        logic [15:0] t1;
        logic [15:0] t2;
        // old format compares against the low byte only
        t1 = legacy_mode ? {8'h00, mem[0]} : {mem[1], mem[0]};
        t2 = legacy_mode ? {8'h00, mem[2]} : {mem[3], mem[2]};
        @(posedge ref_clk);
        m1 <= a;
        m2 <= b;
        m1_v <= 1'b1;
        m2_v <= 1'b1;
        @(posedge ref_clk);
        m1_v <= 1'b0;
        m2_v <= 1'b0;
        @(negedge ref_clk);
        chk("prox1_event", 16'(hit(a, t1)), 16'(ev1));
        chk("prox2_event", 16'(hit(b, t2)), 16'(ev2));
    endtask
    task automatic access(logic [7:0] o, logic [7:0] d);
        logic [7:0] got;
        logic       map;
        map = (o >= 8'h11) && (o <= 8'h14) && !(legacy_mode && !o[0]);
        u_host.wr(o, d);
        if (map)
            mem[2'(o - 8'h11)] = d;
        @(negedge ref_clk);
        chk("prox1_threshold", {mem[1], mem[0]}, th1);
        chk("prox2_threshold", {mem[3], mem[2]}, th2);
        u_host.rd(o, got);
        chk("reg_rdata_r", 16'(map ? mem[2'(o - 8'h11)] : 8'h00),
            16'(got));
    endtask
    task automatic reset_run(int n);
        reset_n <= 1'b0;
        repeat (n) @(posedge ref_clk);
        reset_n <= 1'b1;
        mem = '{default: 8'h00};
        @(negedge ref_clk);
        chk("prox1_threshold", 16'h0000, th1);
        chk("prox2_threshold", 16'h0000, th2);
        chk("reg_rdata_r", 16'h0000, 16'(reg_rdata_r));
        chk("prox1_event", 16'h0000, 16'(ev1));
        chk("prox2_event", 16'h0000, 16'(ev2));
    endtask
    task automatic rand_run(int n);
        logic [31:0] r;
        for (int k = 0; k < n; k++)
        begin
            r = xs();
            @(posedge ref_clk);
            above_sel <= r[16];
            access(8'h10 + 8'(r[15:8] % 8'h06), r[7:0]);
            r = xs();
            meas(r[15:0], r[31:16]);
            meas({mem[1], mem[0]}, 16'hffff);
        end
    endtask
    initial
    begin
        legacy_mode = 1'b0;
        above_sel = 1'b0;
        m1_v = 1'b0;
        m2_v = 1'b0;
        m1 = 16'h0000;
        m2 = 16'h0000;
        mem = '{default: 8'h00};
        reset_run(5);
        $display("test reset done");
        rand_run(60);
        $display("test random access done");
        // stored bytes are nonzero by now, so this proves the clear
        @(posedge ref_clk);
        reset_run(2);
        $display("test mid-run reset done");
        @(posedge ref_clk);
        legacy_mode <= 1'b1;
        rand_run(20);
        $display("test legacy format done");
        test_done();
    end
endmodule
`default_nettype wire
